// ### rtl/config_select_and_ref_mux.sv
// Strap latch, configuration select, reference mux and spread control
`timescale 1ns/1ps
`default_nettype none
module config_select_and_ref_mux
    import cfg_sel_pkg::*;
#(
    parameter int unsigned HOLDOFF_CYC = RUN_HOLDOFF_CYC,
    parameter int unsigned QUIET_CYC   = LOAD_QUIET_CYC
) (
    // Clock and power-on reset
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    // Strap / reference output pin
    input  wire logic                    strap_output_pin_in,
    output logic                         strap_output_pin_out,
    output logic                         strap_output_pin_oe,
    // Shared pins in pick role
    input  wire logic                    config_pick_high,
    input  wire logic                    config_pick_low,
    // Stored configuration flag and two-wire image request
    input  wire logic                    otp_i2c_default_flag,
    input  wire logic                    i2c_load_req,
    input  wire logic [1:0]              i2c_load_index,
    // Programming register write port
    input  wire logic                    reg_write,
    input  wire logic [7:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic [1:0]              switch_mode_field,
    // Reference clocks
    input  wire logic                    ref_source_pin,
    input  wire logic                    crystal_ref_input,
    input  wire logic                    differential_ref_input,
    // Spread spectrum request
    input  wire logic                    spread_enable,
    input  wire logic                    spread_center,
    input  wire logic [5:0]              spread_amount,
    // Status and results
    output logic                         strap_latched,
    output logic                         i2c_enable,
    output logic                         power_up_done,
    output logic                         load_busy,
    output logic                         load_strobe,
    output logic                         load_i2c_default,
    output logic [1:0]                   load_index,
    output logic                         ref_select_diff,
    output logic                         ref_clock,
    output logic                         spread_active,
    output logic                         spread_down,
    output logic [5:0]                   spread_depth
);
    import cfg_sel_pkg::*;

    // ==========================================
    // Helpers
    function automatic logic [1:0] pick_index(input logic hi, input logic lo);
        pick_index = {hi, lo};
    endfunction : pick_index

    function automatic logic [5:0] clamp_spread(input logic center, input logic [5:0] amt);
        logic [5:0] lo;
        logic [5:0] hi;
        lo = center ? CENTER_SPREAD_MIN : DOWN_SPREAD_MIN;
        hi = center ? CENTER_SPREAD_MAX : DOWN_SPREAD_MAX;
        if (amt < lo) begin
            clamp_spread = lo;
        end else if (amt > hi) begin
            clamp_spread = hi;
        end else begin
            clamp_spread = amt;
        end
    endfunction : clamp_spread

    // ==========================================
    // Sequencer
    load_state_t  state;
    logic [31:0]  count;
    logic [1:0]   pick_seen;
    logic         runtime_ok;
    logic [1:0]   pick_now;
    logic         prim_src;

    assign pick_now   = pick_index(config_pick_high, config_pick_low);
    assign runtime_ok = strap_latched && !otp_i2c_default_flag;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= ST_STRAP;
            count <= 32'h0;
        end else begin
            case (state)
                ST_STRAP: begin
                    if (count >= 32'(STRAP_SETTLE_CYC - 1)) begin
                        state <= ST_LOAD;
                        count <= 32'h0;
                    end else begin
                        count <= count + 32'h1;
                    end
                end
                ST_LOAD: begin
                    state <= ST_HOLDOFF;
                    count <= 32'h0;
                end
                ST_HOLDOFF: begin
                    if (count >= 32'(HOLDOFF_CYC - 1)) begin
                        state <= ST_RUN;
                        count <= 32'h0;
                    end else begin
                        count <= count + 32'h1;
                    end
                end
                ST_RUN: begin
                    if (runtime_ok && pick_now != pick_seen) begin
                        state <= ST_RELOAD;
                        count <= 32'h0;
                    end
                end
                ST_RELOAD: begin
                    if (count >= 32'(QUIET_CYC - 1)) begin
                        state <= ST_RUN;
                        count <= 32'h0;
                    end else begin
                        count <= count + 32'h1;
                    end
                end
                default: begin
                    state <= ST_STRAP;
                    count <= 32'h0;
                end
            endcase
        end
    end

    // ==========================================
    // Strap capture, caught while in settle window
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            strap_latched <= 1'b0;
        end else if (state == ST_STRAP) begin
            strap_latched <= strap_output_pin_in;
        end
    end

    assign i2c_enable    = (state != ST_STRAP) && !strap_latched;
    assign power_up_done = (state != ST_STRAP);
    assign load_busy     = (state == ST_STRAP) || (state == ST_LOAD) || (state == ST_RELOAD);

    // ==========================================
    // Configuration image selection
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            load_strobe      <= 1'b0;
            load_i2c_default <= 1'b0;
            load_index       <= CONFIG_ZERO;
            pick_seen        <= CONFIG_ZERO;
        end else begin
            load_strobe <= 1'b0;
            if (state == ST_LOAD) begin
                load_strobe <= 1'b1;
                if (strap_latched) begin
                    load_index       <= pick_now;
                    load_i2c_default <= 1'b0;
                    pick_seen        <= pick_now;
                end else begin
                    load_index       <= CONFIG_ZERO;
                    load_i2c_default <= otp_i2c_default_flag;
                    pick_seen        <= pick_now;
                end
            end else if (state == ST_RUN && runtime_ok && pick_now != pick_seen) begin
                // Host changes one pin per step; the new index loads as is
                load_strobe      <= 1'b1;
                load_index       <= pick_now;
                load_i2c_default <= 1'b0;
                pick_seen        <= pick_now;
            end else if (state == ST_RUN && !strap_latched && i2c_load_req) begin
                load_strobe      <= 1'b1;
                load_index       <= i2c_load_index;
                load_i2c_default <= 1'b0;
            end
        end
    end

    // ==========================================
    // Programming register bit and reference mux
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prim_src <= 1'b0;
        end else if (reg_write && i2c_enable && reg_addr == SOURCE_REG_ADDR) begin
            prim_src <= reg_wdata[PRIMARY_SRC_POS];
        end
    end

    logic ref_source_pin_q;
    logic ref_source_sel;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ref_source_pin_q <= 1'b0;
        end else begin
            ref_source_pin_q <= ref_source_pin;
        end
    end

    assign ref_source_sel = ref_source_pin_q;

    // Selection changes only on clock edges; ref_clock is a plain combinational mux of the two inputs
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ref_select_diff <= 1'b0;
        end else if (!switch_mode_field[1]) begin
            ref_select_diff <= prim_src ^ ref_source_sel;
        end
    end

    assign ref_clock = ref_select_diff ? differential_ref_input : crystal_ref_input;

    // Strap pin drives the reference after power-up
    assign strap_output_pin_oe  = (state != ST_STRAP);
    assign strap_output_pin_out = strap_output_pin_oe ? ref_clock : 1'b0;

    // ==========================================
    // Spread spectrum settings to the fractional dividers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            spread_active <= 1'b0;
            spread_down   <= 1'b0;
            spread_depth  <= 6'h00;
        end else begin
            spread_active <= spread_enable;
            spread_down   <= !spread_center;
            spread_depth  <= spread_enable ? clamp_spread(spread_center, spread_amount) : 6'h00;
        end
    end
endmodule : config_select_and_ref_mux
`default_nettype wire

// ### common/cfg_sel_pkg.sv
// Constants for the configuration select and reference mux block
package cfg_sel_pkg;
    // ==========================================
    // Timing
    localparam int unsigned CLK_HZ            = 40000000;
    localparam int unsigned RUN_HOLDOFF_MS    = 10;
    localparam int unsigned LOAD_QUIET_MS     = 1;
    localparam int unsigned RUN_HOLDOFF_CYC   = CLK_HZ / 1000 * RUN_HOLDOFF_MS;
    localparam int unsigned LOAD_QUIET_CYC    = CLK_HZ / 1000 * LOAD_QUIET_MS;
    localparam int unsigned STRAP_SETTLE_CYC  = 4;
    // ==========================================
    // Register layout
    localparam logic [7:0] SOURCE_REG_ADDR    = 8'h13;
    localparam int unsigned PRIMARY_SRC_POS   = 1;
    localparam int unsigned I2C_DEFAULT_POS   = 7;
    localparam int unsigned CONFIG_COUNT      = 4;
    localparam int unsigned IMAGE_WIDTH       = 8;
    localparam logic [1:0] CONFIG_ZERO        = 2'h0;
    // ==========================================
    // Spread spectrum
    localparam int unsigned SPREAD_WIDTH      = 6;
    localparam logic [5:0] DOWN_SPREAD_MIN    = 6'h05;  // -0.5 % in 0.1 % steps
    localparam logic [5:0] DOWN_SPREAD_MAX    = 6'h32;  // -5.0 %
    localparam logic [5:0] CENTER_SPREAD_MIN  = 6'h02;  // 0.25 % rounded down
    localparam logic [5:0] CENTER_SPREAD_MAX  = 6'h19;  // 2.5 %
    // ==========================================
    // Load sequencer states
    typedef enum logic [2:0] {
        ST_STRAP   = 3'b000,
        ST_LOAD    = 3'b001,
        ST_HOLDOFF = 3'b010,
        ST_RUN     = 3'b011,
        ST_RELOAD  = 3'b100
    } load_state_t;
endpackage : cfg_sel_pkg

// ### sim/cfg_sel_monitor.sv
// Port checks for the configuration select block
`timescale 1ns/1ps
`default_nettype none
module cfg_sel_monitor
    import cfg_sel_pkg::*;
(
    // Clock and reset
    input wire logic       clock,
    input wire logic       rst_n,
    // Watched pins
    input wire logic       config_pick_high,
    input wire logic       config_pick_low,
    input wire logic [1:0] switch_mode_field,
    input wire logic       strap_output_pin_oe,
    // Watched status
    input wire logic       strap_latched,
    input wire logic       i2c_enable,
    input wire logic       power_up_done,
    input wire logic       load_strobe,
    input wire logic       load_i2c_default,
    input wire logic [1:0] load_index,
    input wire logic       ref_select_diff,
    input wire logic       spread_active,
    input wire logic       spread_down,
    input wire logic [5:0] spread_depth
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ==========
    // Assertions
    oe_tracks_done_a: assert property (strap_output_pin_oe == power_up_done)
        else $error("pin drive not tied to power-up");
    i2c_role_a: assert property (power_up_done |-> i2c_enable == !strap_latched)
        else $error("port role wrong");
    strap_hold_a: assert property (power_up_done && $past(power_up_done) |-> $stable(strap_latched))
        else $error("strap changed");
    first_load_a: assert property ($rose(power_up_done) |=> load_strobe)
        else $error("no startup load");
    pick_load_a: assert property (load_strobe && strap_latched |->
        load_index == {config_pick_high, config_pick_low} && !load_i2c_default)
        else $error("pick load wrong");
    mode_hold_a: assert property (switch_mode_field[1] |=> $stable(ref_select_diff))
        else $error("mux moved outside manual");
    down_range_a: assert property (spread_active && spread_down |->
        spread_depth >= DOWN_SPREAD_MIN && spread_depth <= DOWN_SPREAD_MAX)
        else $error("down spread range");
    strobe_single_a: assert property (load_strobe |=> !load_strobe)
        else $error("strobe too long");
    strap_low_load_a: assert property ($rose(power_up_done) && !strap_latched |=> load_index == CONFIG_ZERO)
        else $error("two-wire startup index wrong");
    cover property (load_strobe && strap_latched);
    cover property (load_strobe && load_i2c_default);
    cover property ($changed(ref_select_diff));
endmodule : cfg_sel_monitor
`default_nettype wire

// ### sim/host_gpio_model.sv
// Host side: strap pull and pick pin driver
`timescale 1ns/1ps
`default_nettype none
module host_gpio_model #(
    parameter int unsigned GAP = 12
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // Strap pin wire
    input  wire logic       strap_drive,
    input  wire logic       pin_oe,
    input  wire logic       pin_out,
    output logic            strap_in,
    // Pick pins
    input  wire logic [1:0] target,
    output var logic        pick_high = 1'b0,
    output var logic        pick_low = 1'b0,
    output logic            idle
);
    int unsigned wait_cnt = 0;
    // Device drives once powered up
    assign strap_in = pin_oe ? pin_out : strap_drive;
    assign idle     = (wait_cnt == 0) && ({pick_high, pick_low} == target);
    always @(posedge clock) begin
        if (!rst_n) begin
            pick_high <= target[1];
            pick_low  <= target[0];
            wait_cnt  <= GAP;
        end else if (wait_cnt != 0) begin
            wait_cnt <= wait_cnt - 1;
        end else if (pick_high != target[1]) begin
            pick_high <= target[1];
            wait_cnt  <= GAP;
        end else if (pick_low != target[0]) begin
            pick_low <= target[0];
            wait_cnt <= GAP;
        end
    end
endmodule : host_gpio_model
`default_nettype wire

// ### sim/config_select_and_ref_mux_tb.sv
// Self-checking bench for the configuration select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module config_select_and_ref_mux_tb;
    import cfg_sel_pkg::*;
    logic clock = 0, rst_n = 0, sd = 0, flag = 0, req = 0, wr = 0, src = 0, xtal = 0, diff = 0, sen = 0, sctr = 0;
    logic [1:0] target = 0, ridx = 0, mode = 0;
    logic [7:0] addr = 0, wdata = 0;
    logic [5:0] amt = 0;
    wire logic pin_in, oe, pout, ph, pl, idle, lat, i2c_en, stb, ldef, rsel, sact, sdown, rclk, busy, done;
    wire logic [1:0] lidx;
    wire logic [5:0] sdep;
    int num_errors = 0;
    int tests_run = 0;
    config_select_and_ref_mux #(.HOLDOFF_CYC(20), .QUIET_CYC(10)) u_config_select_and_ref_mux (.clock, .rst_n,
        .strap_output_pin_in(pin_in), .strap_output_pin_out(pout), .strap_output_pin_oe(oe), .config_pick_high(ph),
        .config_pick_low(pl), .otp_i2c_default_flag(flag), .i2c_load_req(req), .i2c_load_index(ridx), .reg_write(wr),
        .reg_addr(addr), .reg_wdata(wdata), .switch_mode_field(mode), .ref_source_pin(src), .crystal_ref_input(xtal),
        .differential_ref_input(diff), .spread_enable(sen), .spread_center(sctr), .spread_amount(amt),
        .strap_latched(lat), .i2c_enable(i2c_en), .power_up_done(done), .load_busy(busy), .load_strobe(stb),
        .load_i2c_default(ldef), .load_index(lidx), .ref_select_diff(rsel), .ref_clock(rclk), .spread_active(sact),
        .spread_down(sdown), .spread_depth(sdep));
    host_gpio_model #(.GAP(12)) u_host_gpio_model (.clock, .rst_n, .strap_drive(sd), .pin_oe(oe), .pin_out(pout),
        .strap_in(pin_in), .target, .pick_high(ph), .pick_low(pl), .idle);
    initial begin
        forever #12.5 clock = ~clock;
    end
    always #7 xtal = ~xtal;
    always #11 diff = ~diff;
    function automatic logic [5:0] clamp(input logic c, input logic [5:0] a);
        logic [5:0] lo, hi;
        lo = c ? CENTER_SPREAD_MIN : DOWN_SPREAD_MIN;
        hi = c ? CENTER_SPREAD_MAX : DOWN_SPREAD_MAX;
        return (a < lo) ? lo : ((a > hi) ? hi : a);
    endfunction : clamp
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic wait_load;
        int k;
        k = 0;
        while (stb !== 1'b1 && k < 100) begin
            tick(1);
            k++;
        end
        `CHK("load strobe", 1'b1, stb)
    endtask : wait_load
    task automatic settle;
        int k;
        k = 0;
        tick(1);
        while (idle !== 1'b1 && k < 200) begin
            tick(1);
            k++;
        end
    endtask : settle
    task automatic power_up(input logic s, input logic f, input logic [1:0] p);
        sd = s;
        flag = f;
        target = p;
        rst_n = 0;
        tick(3);
        rst_n = 1;
        `CHK("busy in strap", 1'b1, busy)
        wait_load();
        `CHK("busy after load", 1'b0, busy)
        `CHK("power-up done", 1'b1, done)
        `CHK("strap", s, lat)
        `CHK("i2c enable", ~s, i2c_en)
        `CHK("index", s ? p : 2'h0, lidx)
        `CHK("image", ~s & f, ldef)
        `CHK("pin drive", 1'b1, oe)
    endtask : power_up
    task automatic complete_run;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    initial begin
        #(25 * 20000);
        num_errors++;
        complete_run();
    end
    initial begin
        void'($urandom(31894));
        for (int i = 0; i < 16; i++) power_up(i[3], i[2], i[1:0]);
        power_up(1'b1, 1'b0, 2'h0);
        tick(25);
        repeat (6) begin
            target = 2'($urandom);
            settle();
            `CHK("run pick", target, lidx)
        end
        flag = 1;
        target = ~lidx;
        settle();
        `CHK("frozen pick", ~target, lidx)
        power_up(1'b0, 1'b0, 2'h3);
        tick(25);
        target = 2'h1;
        settle();
        `CHK("pins ignored", 2'h0, lidx)
        for (int j = 0; j < 4; j++) begin
            ridx = 2'(j);
            req = 1;
            tick(1);
            req = 0;
            wait_load();
            `CHK("i2c image", ridx, lidx)
            tick(12);
        end
        for (int j = 0; j < 4; j++) begin
            wr = 1;
            addr = 8'h13;
            wdata = {6'($urandom), j[1], 1'b0};
            src = j[0];
            tick(1);
            wr = 0;
            tick(3);
            `CHK("ref select", j[1] ^ j[0], rsel)
            `CHK("ref clock", (j[1] ^ j[0]) ? diff : xtal, rclk)
            `CHK("ref out pin", (j[1] ^ j[0]) ? diff : xtal, pin_in)
        end
        wr = 1;
        addr = 8'h12;
        wdata = 8'h00;
        mode = 2'h2;
        src = 0;
        tick(1);
        wr = 0;
        tick(3);
        `CHK("ref held", 1'b0, rsel)
        for (int j = 0; j < 10; j++) begin
            sen = (j < 2) | 1'($urandom);
            sctr = 1'($urandom);
            amt = (j < 2) ? {6{j[0]}} : 6'($urandom);
            tick(2);
            `CHK("spread on", sen, sact)
            if (sen) begin
                `CHK("spread down", ~sctr, sdown)
                `CHK("spread depth", clamp(sctr, amt), sdep)
            end
        end
        complete_run();
    end
endmodule : config_select_and_ref_mux_tb
bind config_select_and_ref_mux cfg_sel_monitor u_cfg_sel_monitor (.clock, .rst_n, .config_pick_high,
    .config_pick_low, .switch_mode_field, .strap_output_pin_oe, .strap_latched, .i2c_enable, .power_up_done,
    .load_strobe, .load_i2c_default, .load_index, .ref_select_diff, .spread_active, .spread_down, .spread_depth);
`default_nettype wire
